// *** bench/tcir_carrier_model.sv ***
// partner: carrier timer channel-1 output feeding the ir gate
// assumes it shares i_clock with the timer block
`timescale 1ns/1ps
module tcir_carrier_model #(
  parameter int PERIOD = 4, // carrier period, cycles
  parameter int DUTY = 2 // cycles high per period
) (
  input wire logic i_clock, // system clock
  input wire logic i_run, // carrier running
  output logic o_carrier // carrier channel-1 output
);
  int cnt; // carrier count
  // set at zero, clear on compare; held low between frames
  always_ff @(posedge i_clock) begin
    if (!i_run) begin
      cnt <= 0;
      o_carrier <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_carrier <= (cnt < DUTY);
    end
  end
endmodule : tcir_carrier_model

// *** bench/tcir_tb_top.sv ***
// self-checking bench: sfr reads, compare outputs, ir gating, flags
// assumes the carrier partner and design share one 20 MHz clock
`timescale 1ns/1ps
`include "tcir_params.svh"
module tcir_tb_top;
  localparam logic [6:0] INIT = 7'h52; // initial level per mode
  logic i_clock = 1'b0; // 50 ns clock
  logic i_rst_b = 1'b0; // sync reset
  logic wr = 1'b0; // write strobe
  logic rd = 1'b0; // read strobe
  logic ten = 1'b1; // timer irq enable
  logic gen = 1'b1; // global irq enable
  int nreq = 0; // requests seen by pulse
  logic fclr = 1'b0; // cpu flag clear
  logic run = 1'b0; // carrier running
  logic [4:0] cap = 5'h00; // capture pulses
  logic [7:0] addr = 8'h00; // sfr address
  logic [7:0] wd = 8'h00; // write data
  logic [7:0] rdat; // read data
  logic [4:0] pin; // channel pins
  logic car, flag, req, d0, d1, d2; // carrier, irq, dma
  int errors = 0;
  int n_checks = 0;
  int k, c;
  logic [7:0] v;
  tcir_carrier_model CAR (.i_clock(i_clock), .i_run(run), .o_carrier(car));
  tcir_top DUT (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_sfr_addr(addr),
    .i_sfr_wdata(wd), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_tick(1'b1), .i_carrier_out(car),
    .i_capture_evt0(cap[0]), .i_capture_evt1(cap[1]), .i_capture_evt2(cap[2]),
    .i_capture_evt3(cap[3]), .i_capture_evt4(cap[4]), .i_timer_irq_enable(ten),
    .i_global_irq_enable(gen), .i_cpu_flag_clear(fclr), .o_sfr_rdata(rdat),
    .o_chan_pin(pin), .o_cpu_timer_irq_flag(flag), .o_irq_req(req),
    .o_dma_trig_chan0(d0), .o_dma_trig_chan1(d1), .o_dma_trig_chan2(d2));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  task automatic step(input int n);
    repeat (n) @(negedge i_clock);
  endtask : step
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge i_clock);
    wr = 1'b0;
  endtask : w
  task automatic r(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clock);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    step(1);
    d = rdat;
  endtask : r
  task automatic pulse(input logic [4:0] p);
    cap = p;
    step(1);
    // request pulse stands in the cycle after the capture edge
    nreq += int'(req === 1'b1);
    cap = 5'h00;
    step(3);
  endtask : pulse
  // cycles between two channel-0 triggers, channel-1 triggers seen
  task automatic gap(output int n, output int m);
    n = 0;
    m = 0;
    while (d0 !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    if (n >= 300) begin
      errors++;
      results;
    end
    n = 0;
    do begin
      step(1);
      n++;
      m += int'(d1 === 1'b1);
    end while (d0 !== 1'b1 && n < 300);
    if (n >= 300) begin
      errors++;
      results;
    end
  endtask : gap
  task automatic ones(input int n, output int m);
    m = 0;
    repeat (n) begin
      step(1);
      m += int'(pin[1] === 1'b1);
    end
  endtask : ones
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_init;
    r(`TCIR_ADDR_CNTH, v);
    chk(v, 8'h00);
    for (int m = 0; m < 7; m++) begin
      w(`TCIR_ADDR_CCTL0 + 8'h02, 8'(m * 8 + 4));
      w(`TCIR_ADDR_CNTL, 8'h00);
      step(3);
      chk(pin[2], INIT[m]);
      w(`TCIR_ADDR_CCTL0 + 8'h02, 8'h3c);
      step(3);
      chk(pin[2], INIT[m]);
    end
  endtask : t_init
  // high byte stays latched while the live count moves on
  task automatic t_latch;
    w(`TCIR_ADDR_CTL, 8'h01);
    w(`TCIR_ADDR_CNTL, 8'h00);
    step(640);
    r(`TCIR_ADDR_CNTL, v);
    r(`TCIR_ADDR_CNTH, v);
    chk(v, 8'h02);
    step(600);
    r(`TCIR_ADDR_CNTH, v);
    chk(v, 8'h02);
  endtask : t_latch
  task automatic t_pwm;
    w(`TCIR_ADDR_CC0L, 8'h10);
    w(`TCIR_ADDR_CC0H, 8'h00);
    w(8'hdc, 8'h04);
    w(8'hdd, 8'h00);
    w(`TCIR_ADDR_CCTL0, 8'h44);
    w(`TCIR_ADDR_CCTL0 + 8'h01, 8'h64);
    w(`TCIR_ADDR_CTL, 8'h02);
    w(`TCIR_ADDR_CNTL, 8'h00);
    gap(k, c);
    chk(8'(k), 8'h11);
    chk(8'(c), 8'h01);
    k = 0;
    repeat (17) begin
      step(1);
      k += int'(d2 === 1'b1);
    end
    chk(8'(k), 8'h01);
    ones(34, k);
    chk(8'(k), 8'h08);
    chk(flag, 1'b1);
    r(`TCIR_ADDR_STAT, v);
    chk(v, 8'h07);
    fclr = 1'b1;
    step(1);
    fclr = 1'b0;
    k = 0;
    repeat (40) begin
      step(1);
      k += int'(req === 1'b1);
    end
    chk(8'(k), 8'h01);
  endtask : t_pwm
  task automatic t_irq;
    w(`TCIR_ADDR_CTL, 8'h00);
    w(`TCIR_ADDR_STAT, 8'h00);
    // flag still set from the pwm run; clear it first
    fclr = 1'b1;
    pulse(5'h00);
    fclr = 1'b0;
    nreq = 0;
    pulse(5'h10);
    chk(flag, 1'b1);
    chk(8'(nreq), 8'h01);
    w(`TCIR_ADDR_CCTL0 + 8'h03, 8'h00);
    fclr = 1'b1;
    gen = 1'b0;
    pulse(5'h00);
    fclr = 1'b0;
    pulse(5'h08);
    chk(flag, 1'b0);
    r(`TCIR_ADDR_STAT, v);
    chk(v, 8'h18);
    pulse(5'h10);
    chk(flag, 1'b1);
    chk(8'(nreq), 8'h01);
    fclr = 1'b1;
    ten = 1'b0;
    gen = 1'b1;
    pulse(5'h00);
    fclr = 1'b0;
    pulse(5'h10);
    chk(8'(nreq), 8'h01);
    fclr = 1'b1;
    pulse(5'h00);
    fclr = 1'b0;
    w(`TCIR_ADDR_STAT, 8'hf7);
    step(3);
    chk(flag, 1'b1);
  endtask : t_irq
  task automatic t_ir;
    w(`TCIR_ADDR_CTL, 8'h02);
    w(`TCIR_ADDR_INFRARED_CONTROL_REG, 8'h01);
    run = 1'b1;
    gap(k, c);
    chk(8'(k), 8'h44);
    ones(68, k);
    chk(8'(k), 8'h08);
    w(`TCIR_ADDR_INFRARED_CONTROL_REG, 8'h00);
    run = 1'b0;
    gap(k, c);
    gap(k, c);
    chk(8'(k), 8'h11);
    ones(34, k);
    chk(8'(k), 8'h08);
  endtask : t_ir
  task automatic results;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  initial begin
    step(4);
    i_rst_b = 1'b1;
    t_init();
    t_latch();
    t_pwm();
    t_irq();
    t_ir();
    results();
  end
endmodule : tcir_tb_top

// *** common/tcir_cnt_if.sv ***
// counter state handed from the counter to the channels
// assumes one system clock for both ends
`timescale 1ns/1ps
interface tcir_cnt_if;
  logic [15:0] count; // live counter value
  logic [15:0] period; // active period value
  logic tick; // counter advance enable
  logic at_zero; // counter value is zero
  logic down; // counting down in up/down mode
  logic updn; // up/down mode selected
  logic init_all; // initialise all outputs
  modport cnt (output count, period, tick, at_zero, down, updn, init_all);
  modport chan (input count, period, tick, at_zero, down, updn, init_all);
endinterface : tcir_cnt_if

// *** common/tcir_params.svh ***
// constants of the timer compare / infrared / interrupt block
// assumes an 8-bit special function register port on one system clock
// Function
// - modes 000, 010, 011 initialise output low
// - modes 001, 100 initialise output high
// - mode 101 clears at period, sets at compare
// - mode 110 sets at period, clears at compare
// - mode 011 set on up-match, clear down/zero
// - mode 100 clear on up-match, set down/zero
// - low-byte write or mode 7 initialises outputs
// - ir mode advances on carrier channel-1 output
// - ir output is glitch-free and of both
// - ir mode routes gated signal to pin
// - channel-1 compare applied only at zero
// - modulo period from channel 0, mark from 1
// - one vector shared by all timer events
// - source flags set regardless of masks
// - masked event sets cpu timer flag
// - clearing one flag re-raises if other masked flags pending
// - dma triggers for channels 0 to 2 only
// - high byte read returns latched value
// - modulo counts 0 to period and wraps
`ifndef TCIR_PARAMS_SVH
`define TCIR_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TCIR_ADDR_STAT 8'haf
`define TCIR_ADDR_CNTL 8'he2
`define TCIR_ADDR_CNTH 8'he3
`define TCIR_ADDR_CTL 8'he4
`define TCIR_ADDR_CCTL0 8'he5
`define TCIR_ADDR_CC0L 8'hda
`define TCIR_ADDR_CC0H 8'hdb
`define TCIR_ADDR_INFRARED_CONTROL_REG 8'hd3
`define TCIR_ADDR_MASK 8'hd8
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define TCIR_CMP_LSB 3
`define TCIR_IM_BIT 6
`define TCIR_CCMODE_BIT 2
`define TCIR_OVF_BIT 5
`define TCIR_CCTL_RESET 8'h40
`define TCIR_CMP_INIT 3'h7
`define TCIR_CH_N 5
`endif

// *** common/tcir_pkg.sv ***
// types of the timer compare / infrared block
// assumes nothing beyond the header constants
package tcir_pkg;
  // counter operating modes
  typedef enum logic [1:0] {
    TCIR_STOP = 2'h0,
    TCIR_FREE = 2'h1,
    TCIR_MOD = 2'h2,
    TCIR_UPDN = 2'h3
  } tcir_mode_t;
  // counter direction in up/down mode
  typedef enum logic {TCIR_UP, TCIR_DOWN} tcir_dir_t;
endpackage : tcir_pkg

// *** core/tcir_channel.sv ***
// one compare channel: buffered compare value and output logic
// assumes counter state from the counter over the interface
`timescale 1ns/1ps
`include "tcir_params.svh"
module tcir_channel (
  input wire logic i_clock, // system clock
  input wire logic i_rst_b, // sync reset, active low
  input wire logic [2:0] i_cmp_mode, // compare mode field
  input wire logic i_cmp_en, // channel in compare mode
  input wire logic i_init, // initialise this output
  input wire logic [15:0] i_wr_value, // new compare value
  input wire logic i_wr, // compare value write
  output logic [15:0] o_active, // value in use
  output logic o_match, // one-cycle compare event
  output logic o_out, // compare output level
  tcir_cnt_if.chan cb // counter state in
);
  logic [15:0] shadow; // written but not yet applied
  logic pending; // shadow waiting for zero
  logic hit; // counter equals compare
  logic hit_per; // counter equals period
  // initial level per mode
  function automatic logic init_level(input logic [2:0] m);
    init_level = (m == 3'h1 || m == 3'h4 || m == 3'h6);
  endfunction : init_level
  assign hit = cb.tick && cb.count == o_active;
  assign hit_per = cb.tick && cb.count == cb.period;
  // ----------------------------------------
  // compare buffer, applied at zero
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      shadow <= 16'h0000;
      pending <= 1'b0;
      o_active <= 16'h0000;
    end else if (i_wr) begin
      shadow <= i_wr_value;
      pending <= 1'b1;
    end else if (pending && cb.at_zero) begin
      o_active <= shadow;
      pending <= 1'b0;
    end
  end
  // ----------------------------------------
  // compare event pulse
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) o_match <= 1'b0;
    else o_match <= hit & i_cmp_en;
  end
  // ----------------------------------------
  // output level per mode
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_out <= 1'b0;
    end else if (i_init || cb.init_all) begin
      o_out <= init_level(i_cmp_mode);
    end else if (i_cmp_en && cb.tick) begin
      unique case (i_cmp_mode)
        3'h0: if (hit) o_out <= 1'b1;
        3'h1: if (hit) o_out <= 1'b0;
        3'h2: if (hit) o_out <= !o_out;
        3'h3: begin
          if (hit) o_out <= !(cb.updn && cb.down);
          else if (!cb.updn && cb.at_zero) o_out <= 1'b0;
        end
        3'h4: begin
          if (hit) o_out <= cb.updn && cb.down;
          else if (!cb.updn && cb.at_zero) o_out <= 1'b1;
        end
        3'h5: begin
          if (hit_per) o_out <= 1'b0;
          else if (hit) o_out <= 1'b1;
        end
        3'h6: begin
          if (hit_per) o_out <= 1'b1;
          else if (hit) o_out <= 1'b0;
        end
        default: ;
      endcase
    end
  end
  // initialisation puts the mode's level out next cycle
  init_level_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_init |=> o_out == init_level($past(i_cmp_mode)))
    else $error("output not initialised to mode level");
  // mode 101 clears on period match
  mode5_clr_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_cmp_en && i_cmp_mode == 3'h5 && hit_per && !i_init && !cb.init_all) |=> !o_out)
    else $error("mode 101 did not clear at period");
  // mode 110 sets on period match
  mode6_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_cmp_en && i_cmp_mode == 3'h6 && hit_per && !i_init && !cb.init_all) |=> o_out)
    else $error("mode 110 did not set at period");
  // buffered value waits for zero
  buf_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (pending && !cb.at_zero && !i_wr) |=> $stable(o_active))
    else $error("compare value applied away from zero");
endmodule : tcir_channel

// *** core/tcir_counter.sv ***
// 16-bit counter with modes and overflow detection
// assumes tick enable and register writes arrive synchronous to i_clock
`timescale 1ns/1ps
`include "tcir_params.svh"
module tcir_counter (
  input wire logic i_clock, // system clock
  input wire logic i_rst_b, // sync reset, active low
  input wire logic i_adv, // advance enable
  input wire logic [1:0] i_mode, // counter mode
  input wire logic [15:0] i_period, // channel-0 period
  input wire logic i_clear, // low-byte write clears
  output logic o_ovf, // one-cycle terminal count
  tcir_cnt_if.cnt cb // counter state out
);
  logic [15:0] count; // counter value
  tcir_pkg::tcir_dir_t dir; // direction
  logic run; // counter enabled
  assign run = i_mode != 2'(tcir_pkg::TCIR_STOP);
  assign cb.count = count;
  assign cb.period = i_period;
  assign cb.tick = i_adv & run;
  assign cb.at_zero = count == 16'h0000;
  assign cb.down = dir == tcir_pkg::TCIR_DOWN;
  assign cb.updn = i_mode == 2'(tcir_pkg::TCIR_UPDN);
  assign cb.init_all = i_clear;
  // ----------------------------------------
  // count process
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    o_ovf <= 1'b0;
    if (!i_rst_b || i_clear) begin
      count <= 16'h0000;
      dir <= tcir_pkg::TCIR_UP;
    end else if (i_adv && run) begin
      unique case (i_mode)
        2'(tcir_pkg::TCIR_FREE): begin
          count <= count + 16'h0001;
          o_ovf <= count == 16'hffff;
        end
        2'(tcir_pkg::TCIR_MOD): begin
          // wrap at period; above it, run to terminal count
          if (count == i_period || count == 16'hffff) begin
            count <= 16'h0000;
            o_ovf <= count == 16'hffff;
          end else begin
            count <= count + 16'h0001;
          end
        end
        default: begin
          // up/down: turnaround at zero flags overflow
          if (dir == tcir_pkg::TCIR_UP) begin
            if (count >= i_period) begin
              dir <= tcir_pkg::TCIR_DOWN;
              count <= count - 16'h0001;
            end else begin
              count <= count + 16'h0001;
            end
          end else if (count == 16'h0001 || count == 16'h0000) begin
            count <= 16'h0000;
            dir <= tcir_pkg::TCIR_UP;
            o_ovf <= 1'b1;
          end else begin
            count <= count - 16'h0001;
          end
        end
      endcase
    end
  end
  // modulo wrap lands on zero one tick after the period
  mod_wrap_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_mode == 2'h2 && i_adv && !i_clear && count == i_period) |=> count == 16'h0000)
    else $error("modulo counter did not wrap at period");
endmodule : tcir_counter

// *** core/tcir_top.sv ***
// timer compare, infrared generation, interrupt and dma trigger block
// assumes an 8-bit sfr port (address, write strobe, read strobe) on i_clock,
// a prescaled tick and a carrier channel-1 output synchronous to i_clock
`timescale 1ns/1ps
`include "tcir_params.svh"
module tcir_top #(
  parameter int CH_N = `TCIR_CH_N // number of channels
) (
  input wire logic i_clock, // system clock, 20 MHz
  input wire logic i_rst_b, // sync reset, active low
  input wire logic [7:0] i_sfr_addr, // sfr address
  input wire logic [7:0] i_sfr_wdata, // sfr write data
  input wire logic i_sfr_wr, // sfr write strobe
  input wire logic i_sfr_rd, // sfr read strobe
  input wire logic i_tick, // prescaled system tick
  input wire logic i_carrier_out, // carrier timer channel-1 output
  input wire logic i_capture_evt0, // channel 0 capture event
  input wire logic i_capture_evt1, // channel 1 capture event
  input wire logic i_capture_evt2, // channel 2 capture event
  input wire logic i_capture_evt3, // channel 3 capture event
  input wire logic i_capture_evt4, // channel 4 capture event
  input wire logic i_timer_irq_enable, // cpu timer interrupt enable
  input wire logic i_global_irq_enable, // cpu global interrupt enable
  input wire logic i_cpu_flag_clear, // cpu clears its timer flag
  output logic [7:0] o_sfr_rdata, // sfr read data
  output logic [CH_N-1:0] o_chan_pin, // channel pins
  output logic o_cpu_timer_irq_flag, // cpu-level timer flag
  output logic o_irq_req, // interrupt request pulse
  output logic o_dma_trig_chan0, // dma trigger, channel 0
  output logic o_dma_trig_chan1, // dma trigger, channel 1
  output logic o_dma_trig_chan2 // dma trigger, channel 2
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] counter_high_byte; // latched high byte
  logic [7:0] ctl; // mode bits
  logic [7:0] infrared_control_reg; // bit 0: ir generation enable
  logic [7:0] source_flag_status; // overflow and channel flags
  logic overflow_irq_mask; // overflow mask
  logic [7:0] cctl [CH_N]; // per-channel control
  logic [7:0] cc_low [CH_N]; // low byte write holding
  logic ir_generation_enable; // ir mode active
  logic carrier_q; // carrier output, last cycle
  logic adv; // counter advance
  logic ovf; // overflow pulse
  logic [CH_N-1:0] match; // compare events
  logic [CH_N-1:0] ch_out; // channel output levels
  logic [CH_N-1:0] evt; // channel events
  logic [15:0] active [CH_N]; // compare values in use
  logic [CH_N-1:0] cc_wr; // high byte writes
  logic [CH_N-1:0] ch_init; // mode-7 initialise
  logic [5:0] ev_all; // all source events
  logic [5:0] mask_all; // all masks
  logic [5:0] clr_bits; // bits cleared by write
  logic [5:0] next_status; // status after update
  logic flag_set; // sets cpu flag
  logic cnt_write; // low byte write
  logic [7:0] rd_mux; // read data mux
  tcir_cnt_if cb ();
  assign ir_generation_enable = infrared_control_reg[0];
  assign cnt_write = i_sfr_wr && i_sfr_addr == `TCIR_ADDR_CNTL;
  // carrier rising edge advances the timer in ir mode
  assign adv = ir_generation_enable ? (i_carrier_out && !carrier_q) : i_tick;
  // ----------------------------------------
  // counter
  // ----------------------------------------
  tcir_counter u_cnt (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_adv(adv),
    .i_mode(ctl[1:0]),
    .i_period(active[0]),
    .i_clear(cnt_write),
    .o_ovf(ovf),
    .cb(cb)
  );
  // ----------------------------------------
  // channels
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_ch
      // 0x7 initialises without storing
      assign ch_init[g] = i_sfr_wr && i_sfr_addr == `TCIR_ADDR_CCTL0 + 8'(g)
        && i_sfr_wdata[`TCIR_CMP_LSB+:3] == `TCIR_CMP_INIT;
      assign cc_wr[g] = i_sfr_wr && i_sfr_addr == `TCIR_ADDR_CC0H + 8'(2 * g);
      tcir_channel u_ch (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_cmp_mode(cctl[g][`TCIR_CMP_LSB+:3]),
        .i_cmp_en(cctl[g][`TCIR_CCMODE_BIT]),
        .i_init(ch_init[g]),
        .i_wr_value({i_sfr_wdata, cc_low[g]}),
        .i_wr(cc_wr[g]),
        .o_active(active[g]),
        .o_match(match[g]),
        .o_out(ch_out[g]),
        .cb(cb)
      );
      // compare event only; capture is merged in at the source flags in capture mode
      assign evt[g] = match[g];
      always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
          cctl[g] <= `TCIR_CCTL_RESET;
          cc_low[g] <= 8'h00;
        end else if (i_sfr_wr) begin
          if (i_sfr_addr == `TCIR_ADDR_CCTL0 + 8'(g)) begin
            if (i_sfr_wdata[`TCIR_CMP_LSB+:3] == `TCIR_CMP_INIT)
              cctl[g] <= {i_sfr_wdata[7:6], cctl[g][5:3], i_sfr_wdata[2:0]};
            else
              cctl[g] <= i_sfr_wdata;
          end
          if (i_sfr_addr == `TCIR_ADDR_CC0L + 8'(2 * g)) cc_low[g] <= i_sfr_wdata;
        end
      end
      assign mask_all[g] = cctl[g][`TCIR_IM_BIT];
    end
  endgenerate
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ctl <= 8'h00;
      infrared_control_reg <= 8'h00;
      overflow_irq_mask <= 1'b1;
    end else if (i_sfr_wr) begin
      if (i_sfr_addr == `TCIR_ADDR_CTL) ctl <= {4'h0, i_sfr_wdata[3:0]};
      if (i_sfr_addr == `TCIR_ADDR_INFRARED_CONTROL_REG) infrared_control_reg <= {7'h00, i_sfr_wdata[0]};
      if (i_sfr_addr == `TCIR_ADDR_MASK) overflow_irq_mask <= i_sfr_wdata[0];
    end
  end
  // ----------------------------------------
  // source flags; set wins over clear
  // ----------------------------------------
  assign ev_all = {ovf, evt | {i_capture_evt4, i_capture_evt3, i_capture_evt2,
    i_capture_evt1, i_capture_evt0} & ~{cctl[4][2], cctl[3][2], cctl[2][2], cctl[1][2], cctl[0][2]}};
  assign mask_all[5] = overflow_irq_mask;
  assign clr_bits = (i_sfr_wr && i_sfr_addr == `TCIR_ADDR_STAT) ? ~i_sfr_wdata[5:0] : 6'h00;
  assign next_status = (source_flag_status[5:0] & ~clr_bits) | ev_all;
  // masked event, or a clear leaving another masked flag pending
  assign flag_set = |(ev_all & mask_all)
    || (|(clr_bits & source_flag_status[5:0]) && |(next_status & mask_all));
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) source_flag_status <= 8'h00;
    else source_flag_status <= {2'h0, next_status};
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) o_cpu_timer_irq_flag <= 1'b0;
    else if (flag_set) o_cpu_timer_irq_flag <= 1'b1;
    else if (i_cpu_flag_clear) o_cpu_timer_irq_flag <= 1'b0;
  end
  // request on rising flag with both enables
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) o_irq_req <= 1'b0;
    else o_irq_req <= flag_set && !o_cpu_timer_irq_flag
      && i_timer_irq_enable && i_global_irq_enable;
  end
  // ----------------------------------------
  // dma triggers, channels 0..2 only
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_dma_trig_chan0 <= 1'b0;
      o_dma_trig_chan1 <= 1'b0;
      o_dma_trig_chan2 <= 1'b0;
    end else begin
      o_dma_trig_chan0 <= match[0];
      o_dma_trig_chan1 <= match[1];
      o_dma_trig_chan2 <= match[2];
    end
  end
  // ----------------------------------------
  // pins and ir gating
  // ----------------------------------------
  // both sources sampled on one clock so the and has no glitch
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      carrier_q <= 1'b0;
      o_chan_pin <= '0;
    end else begin
      carrier_q <= i_carrier_out;
      o_chan_pin <= ch_out;
      if (ir_generation_enable) o_chan_pin[1] <= ch_out[1] & i_carrier_out;
    end
  end
  // ----------------------------------------
  // counter read with high byte latch
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) counter_high_byte <= 8'h00;
    else if (i_sfr_rd && i_sfr_addr == `TCIR_ADDR_CNTL) counter_high_byte <= cb.count[15:8];
  end
  always_comb begin
    rd_mux = 8'h00;
    if (i_sfr_addr == `TCIR_ADDR_CNTL) rd_mux = cb.count[7:0];
    else if (i_sfr_addr == `TCIR_ADDR_CNTH) rd_mux = counter_high_byte;
    else if (i_sfr_addr == `TCIR_ADDR_CTL) rd_mux = ctl;
    else if (i_sfr_addr == `TCIR_ADDR_STAT) rd_mux = source_flag_status;
    else if (i_sfr_addr == `TCIR_ADDR_INFRARED_CONTROL_REG) rd_mux = infrared_control_reg;
    else if (i_sfr_addr == `TCIR_ADDR_MASK) rd_mux = {7'h00, overflow_irq_mask};
    else if (i_sfr_addr >= `TCIR_ADDR_CCTL0 && i_sfr_addr < `TCIR_ADDR_CCTL0 + 8'(CH_N))
      rd_mux = cctl[3'(i_sfr_addr - `TCIR_ADDR_CCTL0)];
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) o_sfr_rdata <= 8'h00;
    else if (i_sfr_rd) o_sfr_rdata <= rd_mux;
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  ir_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    ir_generation_enable |=> o_chan_pin[1] == ($past(ch_out[1]) & $past(i_carrier_out)))
    else $error("ir pin is not the gated carrier");
  plain_pin_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !ir_generation_enable |=> o_chan_pin[1] == $past(ch_out[1]))
    else $error("channel-1 pin not the plain output");
  hi_latch_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_sfr_rd && i_sfr_addr == 8'he2) |=> counter_high_byte == $past(cb.count[15:8]))
    else $error("high byte not latched on low read");
  flag_sticky_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    ev_all[5] |=> source_flag_status[5])
    else $error("overflow flag lost");
  cpu_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (|(ev_all & mask_all)) |=> o_cpu_timer_irq_flag)
    else $error("masked event did not set cpu flag");
  irq_req_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_irq_req |-> $rose(o_cpu_timer_irq_flag) && $past(i_global_irq_enable))
    else $error("request without flag rise or enable");
  dma_trig_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    match[1] |=> o_dma_trig_chan1)
    else $error("channel-1 dma trigger missing");
  ir_adv_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (ir_generation_enable && i_tick && !(i_carrier_out && !carrier_q)) |-> !cb.tick)
    else $error("ir mode advanced on system tick");
endmodule : tcir_top
